/* rtl/bmsp_port_config.v */
// Mode latch and port function selection for the expansion bus pins.
`timescale 1ns/100ps
`default_nettype none
`include "bmsp_defines.vh"
module bmsp_port_config (
	// Clock and reset.
	input wire clk_sys,
	input wire rst,
	// Mode select pins.
	input wire mode_select_high,
	input wire mode_select_mid,
	input wire mode_select_low,
	// Mode register write port.
	input wire mode_wr,
	input wire [2:0] mode_wdata,
	input wire internal_visibility_bit_wdata,
	// Port assignment write port.
	input wire port_assignment_register_wr,
	input wire pipe_status_enable_w,
	input wire low_strobe_enable_w,
	input wire read_write_pin_enable_w,
	input wire e_clock_disable_w,
	// Bus interface control write port.
	input wire bus_interface_control_reg_wr,
	input wire bus_stretch_w,
	// Bus functions from the core.
	input wire bus_clk_stretched,
	input wire bus_clk_free,
	input wire stretch_active,
	input wire bus_rw,
	input wire bus_low_byte_strobe_n,
	input wire pipe_high_in,
	input wire pipe_low_in,
	// Debug command.
	input wire bdm_activate_cmd,
	// Status outputs.
	output reg [2:0] mode_q,
	output reg internal_visibility_bit,
	output reg special_mode,
	output reg bits_writable,
	output reg background_debug_function,
	output reg bus_stretch_control_bit,
	output reg irq_enable,
	output reg nonmaskable_interrupt_input_enable,
	// Port configuration.
	output reg expansion_wide,
	output reg port_ab_pull_en,
	output reg [7:0] port_e_pull_en,
	output reg [7:0] port_e_alt_en,
	output reg [7:0] port_e_out,
	output reg hold_select_rw
);
	reg [2:0] ms1_q, ms2_q, ms3_q;
	reg in_reset_q;
	reg once_q;
	reg pipe_q, lstr_q, rdw_q, e_clock_disable_q;
	wire [2:0] mode_d;
	wire is_single, is_wide, is_normal;
	wire pipe_on, lstr_on, rdw_on, bus_rate_clock_output_on;
	wire mode_ok;

	assign is_single = (mode_q == `BMSP_MODE_SSC) ||
		(mode_q == `BMSP_MODE_NSC);
	assign is_wide = (mode_q == `BMSP_MODE_STW) ||
		(mode_q == `BMSP_MODE_EWX) || (mode_q == `BMSP_MODE_NWX);
	assign is_normal = mode_q[`BMSP_MODE_SPECIAL_BIT];
	// Special modes may rewrite; normal single-chip only once.
	assign mode_ok = mode_wr && !in_reset_q && (mode_q != `BMSP_MODE_PER) &&
		(!is_normal || ((mode_q == `BMSP_MODE_NSC) && !once_q));
	assign mode_d = mode_ok ? mode_wdata : mode_q;
	// Single-chip modes override the enable bits.
	assign pipe_on = pipe_q && !is_single;
	assign lstr_on = lstr_q && !is_single && (mode_q != `BMSP_MODE_NNX);
	assign rdw_on = rdw_q && !is_single;
	assign bus_rate_clock_output_on = !e_clock_disable_q;

	// Pins pass three flops; the first is read by the second only.
	// The chain keeps sampling through reset, since a cleared chain would
	// hand the latch a false code at release.
	always @(posedge clk_sys) begin
		ms1_q <= {mode_select_high, mode_select_mid, mode_select_low};
		ms2_q <= ms1_q;
		ms3_q <= ms2_q;
	end

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			in_reset_q <= 1'b1;
		end else begin
			in_reset_q <= 1'b0;
		end
	end

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mode_q <= 3'h0;
			once_q <= 1'b0;
			internal_visibility_bit <= 1'b0;
			pipe_q <= 1'b0;
			lstr_q <= 1'b0;
			rdw_q <= 1'b0;
			e_clock_disable_q <= 1'b0;
			bus_stretch_control_bit <= 1'b1;
			background_debug_function <= 1'b0;
		end else if (in_reset_q) begin
			// Captured at the first edge after release.
			mode_q <= ms3_q;
			background_debug_function <= (ms3_q == `BMSP_MODE_SSC);
			// Normal single chip starts with bit 4 as a plain input.
			e_clock_disable_q <= (ms3_q == `BMSP_MODE_NSC);
		end else begin
			mode_q <= mode_d;
			if (mode_ok) begin
				internal_visibility_bit <= internal_visibility_bit_wdata;
			end
			if (mode_ok && is_normal) begin
				once_q <= 1'b1;
			end
			if (bdm_activate_cmd) begin
				background_debug_function <= 1'b1;
			end
			// Enables settle the cycle after the write.
			if (port_assignment_register_wr) begin
				pipe_q <= pipe_status_enable_w;
				lstr_q <= low_strobe_enable_w;
				rdw_q <= read_write_pin_enable_w;
				e_clock_disable_q <= e_clock_disable_w;
			end
			if (bus_interface_control_reg_wr) begin
				bus_stretch_control_bit <= bus_stretch_w;
			end
		end
	end

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			special_mode <= 1'b1;
			bits_writable <= 1'b0;
			irq_enable <= 1'b0;
			nonmaskable_interrupt_input_enable <= 1'b0;
			expansion_wide <= 1'b0;
			port_ab_pull_en <= 1'b0;
			port_e_pull_en <= `BMSP_PORTE_PULL_RESET;
			port_e_alt_en <= 8'h00;
			port_e_out <= 8'h00;
			hold_select_rw <= 1'b0;
		end else begin
			special_mode <= !is_normal;
			bits_writable <= !is_normal;
			// Interrupt pins remain plain pulled-up inputs.
			irq_enable <= 1'b0;
			nonmaskable_interrupt_input_enable <= 1'b0;
			expansion_wide <= is_wide && !in_reset_q;
			port_ab_pull_en <= 1'b0;
			// Bits 6 and 5 float for the first cycle after reset release; reset itself pulls all bits.
			port_e_pull_en <= in_reset_q ? `BMSP_PORTE_RESET_MASK :
				{1'b1, 2'h3 & {2{!pipe_on}}, !(bus_rate_clock_output_on || is_wide),
				!lstr_on, !rdw_on, 2'h3};
			port_e_alt_en <= {1'b0, pipe_on, pipe_on,
				bus_rate_clock_output_on || is_wide, lstr_on, rdw_on, 2'h0};
			// Stretched E clock follows the stretch bit.
			port_e_out <= {1'b0, pipe_high_in, pipe_low_in,
				(bus_stretch_control_bit ? bus_clk_stretched :
				bus_clk_free), bus_low_byte_strobe_n, bus_rw, 2'h0};
			// Selects and direction held through stretch in wide modes only.
			hold_select_rw <= stretch_active && is_wide;
		end
	end
endmodule
`default_nettype wire

/* rtl/bmsp_defines.vh */
// Constants for the bus mode select and port configuration block.
// Notes on behaviour
// - Mode pins latched at reset release.
// - Mode bits readable; limited switching allowed.
// - Codes 000 to 011 are special modes.
// - Codes 100 to 111 are normal modes.
// - Debug active after reset only code 000.
// - Normal modes protect bits; special modes relax.
// - Port bits 1,0 pulled-up inputs, interrupts off.
// - Reset sets bus stretch bit in user modes.
// - Port bits 6,5 float the first cycle after reset release.
// - Normal single-chip: all pins general I/O.
// - Single-chip address/data ports: inputs, no pulls.
// - Single-chip: enables reset zero, pins unchanged.
// - Normal single-chip mode accepts one write.
// - Single-chip: clearing disable gives free E clock; code outputs stretched E clock while the stretch bit is set.
// - Wide modes: 16-bit bus, bit 4 E clock.
// - Normal wide: pulled-up inputs until enables set.
// - Pipe enable drives pipe status on 6,5.
// - Read/write enable drives direction on bit 2.
// - Low-strobe enable drives byte strobe on bit 3.
// - Bit 4 E clock follows disable, wide mode, stretch.
// - Stretch holds selects and direction in wide modes, not address.
`ifndef BMSP_DEFINES_VH
`define BMSP_DEFINES_VH
`define BMSP_MODE_SSC 3'h0
`define BMSP_MODE_ENX 3'h1
`define BMSP_MODE_STW 3'h2
`define BMSP_MODE_EWX 3'h3
`define BMSP_MODE_NSC 3'h4
`define BMSP_MODE_NNX 3'h5
`define BMSP_MODE_PER 3'h6
`define BMSP_MODE_NWX 3'h7
`define BMSP_MODE_SPECIAL_BIT 2
`define BMSP_PORTE_W 8
`define BMSP_PORTE_RESET_MASK 8'h9F
`define BMSP_PORTE_PULL_RESET 8'hFF
`endif

/* test/bmsp_port_config_asserts.sv */
// Checker for the mode latch and port selection.
`timescale 1ns/100ps
`default_nettype none
module bmsp_chk (
	// Clock, reset and mode writes.
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic mode_wr,
	input wire logic [2:0] mode_wdata,
	// Watched outputs.
	input wire logic [2:0] mode_q,
	input wire logic background_debug_function,
	input wire logic bus_stretch_control_bit,
	input wire logic expansion_wide,
	input wire logic [7:0] port_e_alt_en
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_tk; !mode_q[2] && mode_wr |=> mode_q == $past(mode_wdata); endproperty
	a_tk: assert property (p_tk) else $error("mode write lost");
	property p_rf; mode_q[2] && mode_q != 3'h4 && mode_wr |=> $stable(mode_q); endproperty
	a_rf: assert property (p_rf) else $error("mode write taken");
	property p_on; mode_q == 3'h4 && mode_wr ##1 mode_wr |=> $stable(mode_q); endproperty
	a_on: assert property (p_on) else $error("second write taken");
	property p_wd; $stable(mode_q)[*2] |-> expansion_wide == (mode_q inside {2, 3, 7}); endproperty
	a_wd: assert property (p_wd) else $error("wide flag wrong");
	property p_sc; $stable(mode_q)[*2] ##0 mode_q[1:0] == 0 |-> (port_e_alt_en & 8'h6c) == 0; endproperty
	a_sc: assert property (p_sc) else $error("single chip pin taken");
	property p_nx; $stable(mode_q)[*2] ##0 mode_q == 3'h5 |-> !port_e_alt_en[3]; endproperty
	a_nx: assert property (p_nx) else $error("narrow strobe on");
	property p_db; $fell(rst) |=> background_debug_function == (mode_q == 0); endproperty
	a_db: assert property (p_db) else $error("debug flag wrong");
	property p_es; $fell(rst) |-> bus_stretch_control_bit; endproperty
	a_es: assert property (p_es) else $error("stretch bit clear");
	c_wr: cover property (mode_wr && mode_q == 3'h4);
	c_wd: cover property (expansion_wide);
	c_rw: cover property ($rose(port_e_alt_en[2]));
endmodule
bind bmsp_port_config bmsp_chk u_chk (.*);
`default_nettype wire

/* test/bmsp_board.sv */
// Board model that straps the mode pins for a requested code.
`timescale 1ns/100ps
`default_nettype none
module bmsp_board (
	// Requested code.
	input wire logic [2:0] code,
	// Strap pins.
	output logic mode_select_high,
	output logic mode_select_mid,
	output logic mode_select_low
);
	// Peripheral code is never strapped, since debug would fight its bus.
	assign {mode_select_high, mode_select_mid, mode_select_low} = (code == 3'h6) ? 3'h7 : code;
endmodule
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the mode latch and port selection.
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic clk_sys = 0, rst = 1, mode_wr = 0, bus_interface_control_reg_wr = 0, port_assignment_register_wr = 0;
	logic bdm_activate_cmd = 0, internal_visibility_bit_wdata = 0, bus_stretch_w = 0;
	logic pipe_status_enable_w = 0, low_strobe_enable_w = 0, bus_rw = 0;
	logic read_write_pin_enable_w = 0, e_clock_disable_w = 0, bus_low_byte_strobe_n = 0;
	logic bus_clk_stretched = 0, bus_clk_free = 0, stretch_active = 0;
	logic pipe_high_in = 0, pipe_low_in = 0, special_mode, irq_enable;
	logic mode_select_high, mode_select_mid, mode_select_low, nonmaskable_interrupt_input_enable;
	logic internal_visibility_bit, bits_writable, background_debug_function;
	logic bus_stretch_control_bit, expansion_wide, port_ab_pull_en, hold_select_rw;
	logic [2:0] code = 0, mode_wdata = 0, mode_q, d;
	logic [7:0] port_e_pull_en, port_e_alt_en, port_e_out;
	int err_count = 0, n_compared = 0, seed = 4, cyc = 0;
	wire [2:0] pins = {mode_select_high, mode_select_mid, mode_select_low};
	bmsp_board u_brd (.*);
	bmsp_port_config DUT (.*);
	initial forever #12.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		{bus_clk_stretched, bus_clk_free, stretch_active, bus_rw} <= cyc[3:0];
		{bus_low_byte_strobe_n, pipe_high_in, pipe_low_in} <= cyc[6:4];
		if (cyc == 3000) stop_test(1);
	end
	// Special modes take any write; plain single chip takes only one.
	function logic [2:0] nxt(input logic [2:0] m, w, v);
		logic [2:0] r;
		logic used;
		r = m;
		used = 1'b0;
		if (!r[2]) r = w;
		else if (r == 3'h4) begin
			r = w;
			used = 1'b1;
		end
		if (!r[2]) r = v;
		else if (r == 3'h4 && !used) r = v;
		nxt = r;
	endfunction
	task chk(input string s, input logic [7:0] e, g);
		n_compared++;
		if (e !== g) err_count++;
		if (e !== g) $display("ERROR %s expected %h seen %h", s, e, g);
	endtask
	task stop_test(input int e);
		err_count += e;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		for (int c = 0; c < 8; c++) begin
			code <= c[2:0];
			rst <= 1;
			repeat (3) @(posedge clk_sys);
			rst <= 0;
			repeat (4) @(negedge clk_sys);
			chk("mode", pins, mode_q);
			chk("debug", pins == 0, background_debug_function);
			chk("stretch", 1, bus_stretch_control_bit);
			chk("special", !pins[2], special_mode);
			chk("ab pulls", 0, port_ab_pull_en);
			chk("irq", 0, {irq_enable, nonmaskable_interrupt_input_enable});
			chk("alt reset", 0, port_e_alt_en & 8'h6c);
			@(posedge clk_sys);
			d = {1'b1, 2'($random(seed))};
			if (d == 3'h6) d = 3'h7;
			{mode_wr, bdm_activate_cmd, mode_wdata} <= {2'b11, d};
			@(posedge clk_sys);
			{bdm_activate_cmd, port_assignment_register_wr, bus_interface_control_reg_wr, mode_wdata} <= {3'b011, d ^ 3'h3};
			{pipe_status_enable_w, low_strobe_enable_w} <= 2'($random(seed));
			{read_write_pin_enable_w, e_clock_disable_w} <= 2'($random(seed));
			{bus_stretch_w, internal_visibility_bit_wdata} <= 2'($random(seed));
			@(posedge clk_sys);
			{mode_wr, port_assignment_register_wr, bus_interface_control_reg_wr} <= 3'h0;
			repeat (4) @(negedge clk_sys);
			d = nxt(pins, d, d ^ 3'h3);
			chk("mode write", d, mode_q);
			chk("debug on", 1, background_debug_function);
			chk("rw pin", read_write_pin_enable_w & (d != 3'h4), port_e_alt_en[2]);
			chk("strobe", low_strobe_enable_w & d[1], port_e_alt_en[3]);
			chk("pipe", {2{pipe_status_enable_w & (d != 3'h4)}}, port_e_alt_en[6:5]);
			chk("stretch w", bus_stretch_w, bus_stretch_control_bit);
			$display("mode %0d done", c);
		end
		stop_test(0);
	end
endmodule
`default_nettype wire
